/* File: rtl/tio_pkg.sv */
// shared constants and types for the console terminal controller and its processor end
package tio_pkg;
    localparam int DATA_W = 16;
    localparam int CODE_W = 6;
    localparam int CHAR_W = 8;
    // device codes as seen on the select lines (octal 10 and 11)
    localparam logic [5:0] CODE_IN = 6'h08;
    localparam logic [5:0] CODE_OUT = 6'h09;
    // bus bit k of the machine (bit 0 = msb) sits at vector index 15-k
    localparam int MASK_BIT_IN = 1;
    localparam int MASK_BIT_OUT = 0;
    localparam int ION_BIT = 0;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [9:0] ZERO_CODE_PAD = 10'h000;
    localparam logic [15:0] ZERO_WORD = 16'h0000;
    // interrupt service: pc is saved here, handler address is fetched from here
    localparam logic [15:0] SAVE_ADDR = 16'h0000;
    localparam logic [15:0] VECTOR_ADDR = 16'h0001;

    typedef enum logic [2:0] {
        TIO_OP_DATA_IN = 3'h0,
        TIO_OP_DATA_OUT = 3'h1,
        TIO_OP_NO_XFER = 3'h2,
        TIO_OP_MASK_OUT = 3'h3,
        TIO_OP_INT_ACK = 3'h4,
        TIO_OP_IO_RESET = 3'h5,
        TIO_OP_INT_ENABLE = 3'h6
    } tio_op_type;
endpackage

/* File: rtl/tio_bus_if.sv */
// programmed i/o bus between processor end and terminal controller
`timescale 1ns/1ps
interface tio_bus_if;
    logic [15:0] data_host;
    logic data_host_oe;
    logic [15:0] data_dev;
    logic data_dev_oe;
    logic [15:0] data;
    logic [5:0] dev_sel;
    logic read_a;
    logic write_a;
    logic start;
    logic clear;
    logic mask_out;
    logic intr_ack;
    logic io_bus_reset;
    logic int_req;
    logic pri_in;
    logic pri_out;

    // resolved bus level; an undriven bus reads as zero
    assign data = data_dev_oe ? data_dev : (data_host_oe ? data_host : tio_pkg::ZERO_WORD);

    modport host (
        output data_host, data_host_oe, dev_sel, read_a, write_a, start, clear,
        output mask_out, intr_ack, io_bus_reset, pri_in,
        input data, int_req
    );
    modport device (
        input data, dev_sel, read_a, write_a, start, clear, mask_out, intr_ack,
        input io_bus_reset, pri_in,
        output data_dev, data_dev_oe, int_req, pri_out
    );
endinterface // tio_bus_if

/* File: rtl/tio_device.sv */
// console terminal controller: input unit and output unit on the programmed i/o bus
//
// Behaviour
// (R1) requesting device holds request until serviced
// (R2) processor takes interrupt only when four conditions hold
// (R3) service saves pc at word 0, jumps via 1
// (R4) service clears global enable until software sets
// (R5) acknowledge returns requesting device code, no polling
// (R6) set mask flag hides unit's interrupt request
// (R7) nearer device on chain wins priority
// (R8) characters eight bits, msb even parity
// (R9) units answer distinct codes from select lines
// (R10) data-out loads accumulator low byte to output
// (R11) data-in gives input byte, upper byte zero
// (R12) output start sets busy, sends character
// (R13) printed: clear busy, set done, request
// (R14) output unit code 11, mask bit 15
// (R15) input unit code 10, mask bit 14
// (R16) keyboard character loads buffer, sets done, requests
// (R17) program clears input done by start pulse
// (R18) input start: busy, clear done, start reader
// (R19) data-in with start returns char, restarts reader
// (R20) clear pulse clears busy and done only
// (R21) program loads output buffer before start
// (R22) bus reset hits all devices, others addressed
// (R23) buffer a read drives bus, write loads
// (R24) request while done set and mask clear
`timescale 1ns/1ps
module tio_device (
    input wire logic clk,
    input wire logic reset_n,
    tio_bus_if.device bus,
    input wire logic kb_toggle,
    input wire logic [7:0] kb_char,
    input wire logic prt_ack_toggle,
    output logic [7:0] prt_char,
    output logic prt_start,
    output logic rdr_start,
    output logic in_busy,
    output logic in_done,
    output logic out_busy,
    output logic out_done,
    output logic parity_err
);
    // terminal-side inputs arrive asynchronously: toggles mark events
    logic kb_tog_meta_q;
    logic kb_tog_sync_q;
    logic kb_tog_prev_q;
    logic [7:0] kb_char_meta_q;
    logic [7:0] kb_char_sync_q;
    logic prt_tog_meta_q;
    logic prt_tog_sync_q;
    logic prt_tog_prev_q;

    logic [7:0] in_buf_q;
    logic [7:0] out_buf_q;
    logic in_busy_q;
    logic in_done_q;
    logic out_busy_q;
    logic out_done_q;
    logic in_mask_q;
    logic out_mask_q;
    logic int_req_q;
    logic pri_out_q;
    logic [15:0] data_dev_q;
    logic data_dev_oe_q;
    logic [7:0] prt_char_q;
    logic prt_start_q;
    logic rdr_start_q;
    logic parity_err_q;

    logic sel_in;
    logic sel_out;
    logic in_start;
    logic in_clear;
    logic out_start;
    logic out_clear;
    logic out_write;
    logic kb_event;
    logic prt_event;
    logic in_req;
    logic out_req;
    logic in_grant;
    logic out_grant;
    logic [7:0] send_byte;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            kb_tog_meta_q <= 1'b0;
            kb_tog_sync_q <= 1'b0;
            kb_tog_prev_q <= 1'b0;
            prt_tog_meta_q <= 1'b0;
            prt_tog_sync_q <= 1'b0;
            prt_tog_prev_q <= 1'b0;
            kb_char_meta_q <= 8'h00;
            kb_char_sync_q <= 8'h00;
        end else begin
            kb_tog_meta_q <= kb_toggle;
            kb_tog_sync_q <= kb_tog_meta_q;
            kb_tog_prev_q <= kb_tog_sync_q;
            prt_tog_meta_q <= prt_ack_toggle;
            prt_tog_sync_q <= prt_tog_meta_q;
            prt_tog_prev_q <= prt_tog_sync_q;
            kb_char_meta_q <= kb_char;
            kb_char_sync_q <= kb_char_meta_q;
        end
    end

    assign kb_event = kb_tog_sync_q ^ kb_tog_prev_q;
    assign prt_event = prt_tog_sync_q ^ prt_tog_prev_q;

    // address decode; io_bus_reset, mask_out and intr_ack ignore the code
    assign sel_in = (bus.dev_sel == tio_pkg::CODE_IN); // (R9) (R15)
    assign sel_out = (bus.dev_sel == tio_pkg::CODE_OUT); // (R9) (R14)
    assign in_start = bus.start & sel_in;
    assign in_clear = bus.clear & sel_in;
    assign out_start = bus.start & sel_out;
    assign out_clear = bus.clear & sel_out;
    assign out_write = bus.write_a & sel_out;

    // a write in the same cycle as start still sends the new byte
    assign send_byte = out_write ? bus.data[7:0] : out_buf_q;

    // input unit flags; the character event is written last so set wins
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            in_busy_q <= 1'b0;
            in_done_q <= 1'b0;
        end else if (bus.io_bus_reset && !kb_event) begin // (R22)
            in_busy_q <= 1'b0;
            in_done_q <= 1'b0;
        end else begin
            if (in_clear) begin // (R20)
                in_busy_q <= 1'b0;
                in_done_q <= 1'b0;
            end
            if (in_start) begin // (R18) (R17) (R19)
                in_busy_q <= 1'b1;
                in_done_q <= 1'b0;
            end
            if (kb_event) begin // (R16) (R18)
                in_busy_q <= 1'b0;
                in_done_q <= 1'b1;
            end
        end
    end

    // input buffer and parity check of each arriving character
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            in_buf_q <= 8'h00;
            parity_err_q <= 1'b0;
        end else if (kb_event) begin // (R16)
            in_buf_q <= kb_char_sync_q;
            parity_err_q <= ^kb_char_sync_q; // (R8)
        end
    end

    // reader start pulse follows every start to the input unit that has no bus reset in the same cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdr_start_q <= 1'b0;
        end else begin
            rdr_start_q <= in_start & ~bus.io_bus_reset; // (R18) (R19)
        end
    end

    // output buffer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            out_buf_q <= 8'h00;
        end else if (out_write) begin // (R10) (R23)
            out_buf_q <= bus.data[7:0];
        end
    end

    // output unit flags; print completion wins over a clear in the same cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            out_busy_q <= 1'b0;
            out_done_q <= 1'b0;
        end else if (bus.io_bus_reset && !prt_event) begin // (R22)
            out_busy_q <= 1'b0;
            out_done_q <= 1'b0;
        end else begin
            if (out_clear) begin // (R20)
                out_busy_q <= 1'b0;
                out_done_q <= 1'b0;
            end
            if (out_start) begin // (R12)
                out_busy_q <= 1'b1;
                out_done_q <= 1'b0;
            end
            if (prt_event) begin // (R13)
                out_busy_q <= 1'b0;
                out_done_q <= 1'b1;
            end
        end
    end

    // character to the printer carries even parity in its msb
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prt_char_q <= 8'h00;
            prt_start_q <= 1'b0;
        end else begin
            prt_start_q <= out_start & ~bus.io_bus_reset; // (R12)
            if (out_start) begin
                prt_char_q <= {^send_byte[6:0], send_byte[6:0]}; // (R8) (R21)
            end
        end
    end

    // mask flags are loaded by every mask-out without a bus reset in the same cycle, whatever the select code
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            in_mask_q <= 1'b0;
            out_mask_q <= 1'b0;
        end else if (bus.io_bus_reset) begin // (R22)
            in_mask_q <= 1'b0;
            out_mask_q <= 1'b0;
        end else if (bus.mask_out) begin
            in_mask_q <= bus.data[tio_pkg::MASK_BIT_IN]; // (R15)
            out_mask_q <= bus.data[tio_pkg::MASK_BIT_OUT]; // (R14)
        end
    end

    // requests stay up until done is cleared by the service routine or the unit's mask flag is set
    assign in_req = in_done_q & ~in_mask_q; // (R24) (R6) (R1)
    assign out_req = out_done_q & ~out_mask_q; // (R24) (R6) (R1)
    // input unit sits nearer the processor on the chain than the output unit
    assign in_grant = in_req & bus.pri_in; // (R7)
    assign out_grant = out_req & bus.pri_in & ~in_req; // (R7)

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            int_req_q <= 1'b0;
            pri_out_q <= 1'b0;
        end else begin
            int_req_q <= in_req | out_req; // (R1)
            pri_out_q <= bus.pri_in & ~(in_req | out_req); // (R7)
        end
    end

    // bus answers are driven for exactly the cycle after the strobe
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            data_dev_q <= 16'h0000;
            data_dev_oe_q <= 1'b0;
        end else if (bus.read_a & sel_in) begin // (R23)
            data_dev_q <= {tio_pkg::ZERO_BYTE, in_buf_q}; // (R11)
            data_dev_oe_q <= 1'b1;
        end else if (bus.intr_ack & in_grant) begin // (R5)
            data_dev_q <= {tio_pkg::ZERO_CODE_PAD, tio_pkg::CODE_IN};
            data_dev_oe_q <= 1'b1;
        end else if (bus.intr_ack & out_grant) begin // (R5)
            data_dev_q <= {tio_pkg::ZERO_CODE_PAD, tio_pkg::CODE_OUT};
            data_dev_oe_q <= 1'b1;
        end else begin
            data_dev_q <= 16'h0000;
            data_dev_oe_q <= 1'b0;
        end
    end

    assign bus.data_dev = data_dev_q;
    assign bus.data_dev_oe = data_dev_oe_q;
    assign bus.int_req = int_req_q;
    assign bus.pri_out = pri_out_q;
    assign prt_char = prt_char_q;
    assign prt_start = prt_start_q;
    assign rdr_start = rdr_start_q;
    assign in_busy = in_busy_q;
    assign in_done = in_done_q;
    assign out_busy = out_busy_q;
    assign out_done = out_done_q;
    assign parity_err = parity_err_q;
endmodule // tio_device

/* File: rtl/tio_host.sv */
// processor end: issues programmed i/o bus cycles and runs the interrupt service entry
`timescale 1ns/1ps
module tio_host (
    input wire logic clk,
    input wire logic reset_n,
    tio_bus_if.host bus,
    input wire logic cmd_valid,
    input wire tio_pkg::tio_op_type cmd_op,
    input wire logic [5:0] cmd_code,
    input wire logic cmd_start,
    input wire logic cmd_clear,
    input wire logic [15:0] cmd_data,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [15:0] rsp_data,
    input wire logic fetch_done,
    input wire logic dch_wait,
    input wire logic [15:0] pc,
    output logic mem_wr,
    output logic mem_rd,
    output logic [15:0] mem_addr,
    output logic [15:0] mem_wdata,
    input wire logic [15:0] mem_rdata,
    output logic [15:0] new_pc,
    output logic new_pc_valid,
    output logic global_interrupt_enable
);
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_STROBE = 6'h02,
        ST_PULSE = 6'h04,
        ST_SAVE = 6'h08,
        ST_VECTOR = 6'h10,
        ST_LOAD = 6'h20
    } tio_host_state_type;

    tio_host_state_type state_q;
    tio_pkg::tio_op_type op_q;
    logic start_pend_q;
    logic clear_pend_q;
    logic ion_q;
    logic accept;
    logic take_int;
    logic [15:0] data_host_q;
    logic data_host_oe_q;
    logic [5:0] dev_sel_q;
    logic read_a_q;
    logic write_a_q;
    logic start_q;
    logic clear_q;
    logic mask_out_q;
    logic intr_ack_q;
    logic io_bus_reset_q;
    logic pri_in_q;
    logic cmd_ready_q;
    logic rsp_valid_q;
    logic [15:0] rsp_data_q;
    logic mem_wr_q;
    logic mem_rd_q;
    logic [15:0] mem_addr_q;
    logic [15:0] mem_wdata_q;
    logic [15:0] new_pc_q;
    logic new_pc_valid_q;

    // a command offered in a cycle wins over interrupt entry in that cycle
    assign accept = (state_q == ST_IDLE) & cmd_valid & cmd_ready_q;
    assign take_int = (state_q == ST_IDLE) & ~accept & fetch_done & bus.int_req
                      & ion_q & ~dch_wait; // (R2)

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ion_q <= 1'b0;
        end else if (take_int) begin
            ion_q <= 1'b0; // (R4)
        end else if (accept && cmd_op == tio_pkg::TIO_OP_INT_ENABLE) begin
            ion_q <= cmd_data[tio_pkg::ION_BIT];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pri_in_q <= 1'b0;
        end else begin
            pri_in_q <= 1'b1; // (R7)
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            op_q <= tio_pkg::TIO_OP_NO_XFER;
            start_pend_q <= 1'b0;
            clear_pend_q <= 1'b0;
            data_host_q <= 16'h0000;
            data_host_oe_q <= 1'b0;
            dev_sel_q <= 6'h00;
            read_a_q <= 1'b0;
            write_a_q <= 1'b0;
            start_q <= 1'b0;
            clear_q <= 1'b0;
            mask_out_q <= 1'b0;
            intr_ack_q <= 1'b0;
            io_bus_reset_q <= 1'b0;
            cmd_ready_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_data_q <= 16'h0000;
            mem_wr_q <= 1'b0;
            mem_rd_q <= 1'b0;
            mem_addr_q <= 16'h0000;
            mem_wdata_q <= 16'h0000;
            new_pc_q <= 16'h0000;
            new_pc_valid_q <= 1'b0;
        end else begin
            rsp_valid_q <= 1'b0;
            new_pc_valid_q <= 1'b0;
            mem_wr_q <= 1'b0;
            mem_rd_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    cmd_ready_q <= 1'b1;
                    if (accept) begin
                        cmd_ready_q <= 1'b0;
                        op_q <= cmd_op;
                        start_pend_q <= cmd_start;
                        clear_pend_q <= cmd_clear;
                        dev_sel_q <= cmd_code;
                        data_host_q <= cmd_data;
                        data_host_oe_q <= (cmd_op == tio_pkg::TIO_OP_DATA_OUT)
                                          | (cmd_op == tio_pkg::TIO_OP_MASK_OUT);
                        read_a_q <= (cmd_op == tio_pkg::TIO_OP_DATA_IN);
                        write_a_q <= (cmd_op == tio_pkg::TIO_OP_DATA_OUT);
                        mask_out_q <= (cmd_op == tio_pkg::TIO_OP_MASK_OUT);
                        intr_ack_q <= (cmd_op == tio_pkg::TIO_OP_INT_ACK);
                        io_bus_reset_q <= (cmd_op == tio_pkg::TIO_OP_IO_RESET);
                        state_q <= ST_STROBE;
                    end else if (take_int) begin
                        cmd_ready_q <= 1'b0;
                        mem_wr_q <= 1'b1; // (R3)
                        mem_addr_q <= tio_pkg::SAVE_ADDR;
                        mem_wdata_q <= pc;
                        state_q <= ST_SAVE;
                    end
                end
                ST_STROBE: begin
                    // start and clear follow the data strobe by one cycle
                    read_a_q <= 1'b0;
                    write_a_q <= 1'b0;
                    mask_out_q <= 1'b0;
                    intr_ack_q <= 1'b0;
                    io_bus_reset_q <= 1'b0;
                    data_host_oe_q <= 1'b0;
                    start_q <= start_pend_q; // (R21) (R17)
                    clear_q <= clear_pend_q;
                    state_q <= ST_PULSE;
                end
                ST_PULSE: begin
                    start_q <= 1'b0;
                    clear_q <= 1'b0;
                    rsp_valid_q <= 1'b1;
                    if (op_q == tio_pkg::TIO_OP_DATA_IN || op_q == tio_pkg::TIO_OP_INT_ACK) begin
                        rsp_data_q <= bus.data; // (R5)
                    end else begin
                        rsp_data_q <= 16'h0000;
                    end
                    cmd_ready_q <= 1'b1;
                    state_q <= ST_IDLE;
                end
                ST_SAVE: begin
                    mem_rd_q <= 1'b1; // (R3)
                    mem_addr_q <= tio_pkg::VECTOR_ADDR;
                    state_q <= ST_VECTOR;
                end
                ST_VECTOR: begin
                    state_q <= ST_LOAD;
                end
                ST_LOAD: begin
                    new_pc_q <= mem_rdata; // (R3)
                    new_pc_valid_q <= 1'b1;
                    cmd_ready_q <= 1'b1;
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    assign bus.data_host = data_host_q;
    assign bus.data_host_oe = data_host_oe_q;
    assign bus.dev_sel = dev_sel_q;
    assign bus.read_a = read_a_q;
    assign bus.write_a = write_a_q;
    assign bus.start = start_q;
    assign bus.clear = clear_q;
    assign bus.mask_out = mask_out_q;
    assign bus.intr_ack = intr_ack_q;
    assign bus.io_bus_reset = io_bus_reset_q;
    assign bus.pri_in = pri_in_q;
    assign cmd_ready = cmd_ready_q;
    assign rsp_valid = rsp_valid_q;
    assign rsp_data = rsp_data_q;
    assign mem_wr = mem_wr_q;
    assign mem_rd = mem_rd_q;
    assign mem_addr = mem_addr_q;
    assign mem_wdata = mem_wdata_q;
    assign new_pc = new_pc_q;
    assign new_pc_valid = new_pc_valid_q;
    assign global_interrupt_enable = ion_q;
endmodule // tio_host

/* File: bench/tio_assertions.sv */
// concurrent checks on the programmed i/o bus between the two ends
`timescale 1ns/1ps
module tio_assertions (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [15:0] data,
    input wire logic data_dev_oe,
    input wire logic [5:0] dev_sel,
    input wire logic read_a,
    input wire logic write_a,
    input wire logic start,
    input wire logic clear,
    input wire logic mask_out,
    input wire logic intr_ack,
    input wire logic io_bus_reset,
    input wire logic int_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    chk_read_upper_zero: assert property (data_dev_oe |-> data[15:8] == 8'h00)
        else $error("device drove a nonzero upper byte");
    chk_input_read_answer: assert property (
        read_a && dev_sel == tio_pkg::CODE_IN |=> data_dev_oe)
        else $error("input unit did not drive its buffer");
    chk_output_no_read: assert property (
        read_a && dev_sel == tio_pkg::CODE_OUT |=> !data_dev_oe)
        else $error("output unit answered a data-in");
    chk_ack_code: assert property (intr_ack |=> data[15:6] == 10'h000 &&
        (data[5:0] == tio_pkg::CODE_IN || data[5:0] == tio_pkg::CODE_OUT || data[5:0] == 6'h00))
        else $error("acknowledge returned a bad device code");
    chk_bus_reset_all: assert property (io_bus_reset |-> ##2 !int_req)
        else $error("request survived the bus reset");
    chk_mask_hides: assert property (mask_out && data[1:0] == 2'b11 |-> ##2 !int_req)
        else $error("request shown while both units masked");
    // a request may only drop because of a pulse that clears done or sets a mask
    chk_req_holds: assert property ($fell(int_req) |->
        $past(start || clear || io_bus_reset || mask_out, 2))
        else $error("request dropped without service");
    chk_drive_cause: assert property ($rose(data_dev_oe) |-> $past(read_a || intr_ack))
        else $error("device drove the bus unasked");
    chk_write_no_drive: assert property (write_a |=> !data_dev_oe)
        else $error("device drove the bus during a data-out");
endmodule // tio_assertions

/* File: bench/tio_tb.sv */
// self-checking bench: host end and terminal controller joined by the bus interface
`timescale 1ns/1ps
module tio_tb;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic cmd_valid = 1'b0;
    tio_pkg::tio_op_type cmd_op = tio_pkg::TIO_OP_NO_XFER;
    logic [5:0] cmd_code = 6'h00;
    logic cmd_start = 1'b0;
    logic cmd_clear = 1'b0;
    logic [15:0] cmd_data = 16'h0000;
    logic fetch_done = 1'b0;
    logic dch_wait = 1'b0;
    logic [15:0] pc = 16'h1234;
    logic [15:0] mem_rdata = 16'h0200;
    logic kb_toggle = 1'b0;
    logic [7:0] kb_char = 8'h00;
    logic prt_ack_toggle = 1'b0;
    logic cmd_ready, rsp_valid, mem_wr, mem_rd, new_pc_valid, global_interrupt_enable;
    logic [15:0] rsp_data, mem_addr, mem_wdata, new_pc, rsp;
    logic [7:0] prt_char;
    logic in_busy, in_done, out_busy, out_done, parity_err, prt_start, rdr_start;
    logic [1:0] pls;
    logic [15:0] flags;
    int bad_count = 0;
    int n_checks = 0;
    int cycles = 0;
    int n;

    tio_bus_if bus();
    assign flags = {10'h000, in_busy, in_done, out_busy, out_done, bus.int_req, parity_err};

    tio_host u_tio_host (.clk(clk), .reset_n(reset_n), .bus(bus), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_code(cmd_code), .cmd_start(cmd_start), .cmd_clear(cmd_clear),
        .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .fetch_done(fetch_done), .dch_wait(dch_wait), .pc(pc),
        .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .new_pc(new_pc), .new_pc_valid(new_pc_valid),
        .global_interrupt_enable(global_interrupt_enable));
    tio_device u_tio_device (.clk(clk), .reset_n(reset_n), .bus(bus), .kb_toggle(kb_toggle),
        .kb_char(kb_char), .prt_ack_toggle(prt_ack_toggle), .prt_char(prt_char),
        .prt_start(prt_start), .rdr_start(rdr_start), .in_busy(in_busy), .in_done(in_done),
        .out_busy(out_busy), .out_done(out_done), .parity_err(parity_err));
    tio_assertions u_tio_assertions (.clk(clk), .reset_n(reset_n), .data(bus.data),
        .data_dev_oe(bus.data_dev_oe), .dev_sel(bus.dev_sel), .read_a(bus.read_a),
        .write_a(bus.write_a), .start(bus.start), .clear(bus.clear), .mask_out(bus.mask_out),
        .intr_ack(bus.intr_ack), .io_bus_reset(bus.io_bus_reset), .int_req(bus.int_req));

    initial begin
        forever #10 clk = ~clk;
    end

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // generous ceiling: the whole sequence needs well under 1000 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count++;
            stop_test();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tdone(input string name);
        $display("test %s done", name);
    endtask

    // one command on the host port; answer lands two edges after the taking edge
    task automatic cmd(input tio_pkg::tio_op_type op, input logic [5:0] code,
                       input logic [1:0] sc, input logic [15:0] d);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_code = code;
        cmd_start = sc[1];
        cmd_clear = sc[0];
        cmd_data = d;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        cmd_valid = 1'b0;
        repeat (2) @(negedge clk);
        chk({15'h0000, rsp_valid}, 16'h0001);
        rsp = rsp_data;
        pls = {prt_start, rdr_start};
        @(negedge clk);
    endtask

    // keyboard char held steady around its toggle, since the device syncs it late
    task automatic key(input logic [7:0] c);
        kb_char = c;
        repeat (3) @(negedge clk);
        kb_toggle = ~kb_toggle;
        repeat (8) @(negedge clk);
    endtask

    task automatic printed;
        prt_ack_toggle = ~prt_ack_toggle;
        repeat (8) @(negedge clk);
    endtask

    initial begin
        repeat (5) @(negedge clk);
        reset_n = 1'b1;
        repeat (2) @(negedge clk);
        chk(flags, 16'h0000);
        tdone("reset");
        cmd(tio_pkg::TIO_OP_DATA_OUT, tio_pkg::CODE_OUT, 2'b00, 16'h7f43);
        chk(flags, 16'h0000);
        cmd(tio_pkg::TIO_OP_NO_XFER, tio_pkg::CODE_OUT, 2'b10, 16'h0000);
        chk(flags, 16'h0008);
        chk({8'h00, prt_char}, 16'h00c3);
        chk({14'h0000, pls}, 16'h0002);
        printed();
        chk(flags, 16'h0006);
        cmd(tio_pkg::TIO_OP_INT_ACK, 6'h00, 2'b00, 16'h0000);
        chk(rsp, 16'h0009);
        tdone("output");
        key(8'h35);
        chk(flags, 16'h0016);
        cmd(tio_pkg::TIO_OP_INT_ACK, 6'h00, 2'b00, 16'h0000);
        chk(rsp, 16'h0008);
        cmd(tio_pkg::TIO_OP_DATA_IN, tio_pkg::CODE_IN, 2'b00, 16'h0000);
        chk(rsp, 16'h0035);
        cmd(tio_pkg::TIO_OP_DATA_IN, tio_pkg::CODE_OUT, 2'b00, 16'h0000);
        chk(rsp, 16'h0000);
        cmd(tio_pkg::TIO_OP_DATA_IN, tio_pkg::CODE_IN, 2'b10, 16'h0000);
        chk(rsp, 16'h0035);
        chk({14'h0000, pls}, 16'h0001);
        chk(flags, 16'h0026);
        key(8'hb5);
        chk(flags, 16'h0017);
        tdone("input");
        cmd(tio_pkg::TIO_OP_NO_XFER, tio_pkg::CODE_OUT, 2'b01, 16'h0000);
        chk(flags, 16'h0013);
        cmd(tio_pkg::TIO_OP_MASK_OUT, 6'h00, 2'b00, 16'h0002);
        chk(flags, 16'h0011);
        cmd(tio_pkg::TIO_OP_MASK_OUT, 6'h00, 2'b00, 16'h0001);
        chk(flags, 16'h0013);
        tdone("mask");
        cmd(tio_pkg::TIO_OP_INT_ENABLE, 6'h00, 2'b00, 16'h0001);
        dch_wait = 1'b1;
        fetch_done = 1'b1;
        repeat (6) @(negedge clk);
        chk({15'h0000, global_interrupt_enable}, 16'h0001);
        dch_wait = 1'b0;
        n = 0;
        while (mem_wr !== 1'b1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        fetch_done = 1'b0;
        chk(mem_addr, 16'h0000);
        chk(mem_wdata, 16'h1234);
        chk({15'h0000, global_interrupt_enable}, 16'h0000);
        @(negedge clk);
        chk({mem_rd, mem_addr[14:0]}, 16'h8001);
        n = 0;
        while (new_pc_valid !== 1'b1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        chk(new_pc, 16'h0200);
        tdone("interrupt");
        cmd(tio_pkg::TIO_OP_DATA_OUT, tio_pkg::CODE_OUT, 2'b10, 16'h0041);
        chk(flags, 16'h001b);
        chk({8'h00, prt_char}, 16'h0041);
        cmd(tio_pkg::TIO_OP_MASK_OUT, 6'h00, 2'b00, 16'h0003);
        chk(flags, 16'h0019);
        cmd(tio_pkg::TIO_OP_IO_RESET, 6'h3f, 2'b00, 16'h0000);
        chk(flags & 16'h003e, 16'h0000);
        cmd(tio_pkg::TIO_OP_NO_XFER, tio_pkg::CODE_IN, 2'b10, 16'h0000);
        chk(flags & 16'h003e, 16'h0020);
        tdone("bus reset");
        stop_test();
    end
endmodule // tio_tb
